//--- verilog/sbd_mover.sv
// Single-channel byte DMA between on-chip memory and the SCSI core.
// Assumes a one-cycle memory read, a valid/ready byte port on each side of
// the SCSI core and a register port with read data one cycle after the strobe.
//
// Contract
// - Move up to 256 bytes per transfer with automatic core handshake.
// - Length 8 bits; zero means 256 bytes.
// - 16-bit address from low and high bytes; source or destination.
// - Direction comes only from the SCSI I/O phase line.
// - Bit 4 high for core-to-memory, low for memory-to-core.
// - Read-only bit 3 reads 1 after normal completion.
// - Writing 1 to bit 0 starts with current length and address.
// - Bit 0 stays 1 until completion or a 0 write while not moving.
// - With bit 0 low, status valid and length holds bytes remaining.
// - With enable bit 1 set, interrupt on each 1-to-0 of bit 0.
// - Address reads current value; after interruption holds next address.
// - Interrupt register bit 0 effective only while enable bit is set.
`timescale 1ns/100ps
module sbd_mover (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Register port
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // SCSI phase
    input wire logic scsi_io,
    // Bytes to the SCSI core
    output logic [7:0] tx_data,
    output logic tx_valid,
    input wire logic tx_ready,
    // Bytes from the SCSI core
    input wire logic [7:0] rx_data,
    input wire logic rx_valid,
    output logic rx_ready,
    // Memory port
    output logic [15:0] mem_addr,
    output logic mem_re,
    input wire logic [7:0] mem_rdata,
    output logic mem_we,
    output logic [7:0] mem_wdata,
    // Interrupt
    output logic irq
);

    // ****************************************
    // Declarations
    // ****************************************
    sbd_pkg::sbd_state_e state_reg;
    sbd_pkg::sbd_state_e state_next;
    logic tip_reg;
    logic ien_reg;
    logic tc_reg;
    logic dir_reg;
    logic mask_reg;
    logic [7:0] tx_data_reg;
    logic [7:0] wdata_reg;
    logic [7:0] rdata_reg;
    logic [7:0] count;
    logic [15:0] addr;
    logic int_flag;
    logic ds_wr;
    logic start;
    logic abort;
    logic tx_fire;
    logic step;
    logic last;
    logic done;
    logic tip_fall;
    logic sw_load;

    // ****************************************
    // Register decode
    // ****************************************
    assign ds_wr = reg_wr && (reg_addr == sbd_pkg::SBD_ADDR_CTRL_STATUS);
    assign start = ds_wr && reg_wdata[sbd_pkg::SBD_BIT_IN_PROGRESS] && !tip_reg;
    // A stop is only taken while no byte is mid-move; a stop that meets a
    // completing handshake is dropped so the byte is not lost
    assign abort = ds_wr && !reg_wdata[sbd_pkg::SBD_BIT_IN_PROGRESS] && tip_reg
        && ((state_reg == sbd_pkg::SBD_ST_RECV && !rx_valid)
        || (state_reg == sbd_pkg::SBD_ST_SEND && !tx_ready));
    // Length and address are the live counters, so writes made while busy are dropped
    assign sw_load = reg_wr && !tip_reg;

    // ****************************************
    // Byte engine
    // ****************************************
    assign tx_fire = (state_reg == sbd_pkg::SBD_ST_SEND) && tx_ready;
    assign step = tx_fire || (state_reg == sbd_pkg::SBD_ST_WRITE);
    assign last = (count == sbd_pkg::SBD_COUNT_ONE);
    assign done = step && last;
    assign tip_fall = tip_reg && (done || abort);

    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            sbd_pkg::SBD_ST_IDLE:
            begin
                if (start)
                begin
                    // Direction is picked from the phase line, never software
                    state_next = scsi_io ? sbd_pkg::SBD_ST_RECV
                        : sbd_pkg::SBD_ST_FETCH;
                end
            end
            sbd_pkg::SBD_ST_FETCH:
            begin
                state_next = sbd_pkg::SBD_ST_LATCH;
            end
            sbd_pkg::SBD_ST_LATCH:
            begin
                state_next = sbd_pkg::SBD_ST_SEND;
            end
            sbd_pkg::SBD_ST_SEND:
            begin
                if (abort)
                begin
                    state_next = sbd_pkg::SBD_ST_IDLE;
                end
                else if (tx_fire)
                begin
                    state_next = last ? sbd_pkg::SBD_ST_IDLE
                        : (scsi_io ? sbd_pkg::SBD_ST_RECV : sbd_pkg::SBD_ST_FETCH);
                end
            end
            sbd_pkg::SBD_ST_RECV:
            begin
                if (abort)
                begin
                    state_next = sbd_pkg::SBD_ST_IDLE;
                end
                else if (rx_valid)
                begin
                    state_next = sbd_pkg::SBD_ST_WRITE;
                end
            end
            sbd_pkg::SBD_ST_WRITE:
            begin
                state_next = last ? sbd_pkg::SBD_ST_IDLE
                    : (scsi_io ? sbd_pkg::SBD_ST_RECV : sbd_pkg::SBD_ST_FETCH);
            end
            default:
            begin
                state_next = sbd_pkg::SBD_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= sbd_pkg::SBD_ST_IDLE;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // Fetched byte is held steady for the core until it takes it
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_data_reg <= 8'h00;
        end
        else if (state_reg == sbd_pkg::SBD_ST_LATCH)
        begin
            tx_data_reg <= mem_rdata;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wdata_reg <= 8'h00;
        end
        else if (state_reg == sbd_pkg::SBD_ST_RECV && rx_valid)
        begin
            wdata_reg <= rx_data;
        end
    end

    assign tx_data = tx_data_reg;
    assign tx_valid = (state_reg == sbd_pkg::SBD_ST_SEND);
    assign rx_ready = (state_reg == sbd_pkg::SBD_ST_RECV);
    assign mem_addr = addr;
    assign mem_re = (state_reg == sbd_pkg::SBD_ST_FETCH);
    assign mem_we = (state_reg == sbd_pkg::SBD_ST_WRITE);
    assign mem_wdata = wdata_reg;

    sbd_xfer_ctr u_ctr (
        .clock(clock),
        .rst_n(rst_n),
        .load_len(sw_load && reg_addr == sbd_pkg::SBD_ADDR_LENGTH),
        .load_lo(sw_load && reg_addr == sbd_pkg::SBD_ADDR_ADDRESS_LOW),
        .load_hi(sw_load && reg_addr == sbd_pkg::SBD_ADDR_ADDRESS_HIGH),
        .load_data(reg_wdata),
        .step(step),
        .count_reg(count),
        .addr_reg(addr)
    );

    // ****************************************
    // Control and status bits
    // ****************************************
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tip_reg <= 1'b0;
        end
        else if (start)
        begin
            tip_reg <= 1'b1;
        end
        else if (done || abort)
        begin
            tip_reg <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tc_reg <= 1'b0;
        end
        else if (start)
        begin
            tc_reg <= 1'b0;
        end
        else if (done)
        begin
            tc_reg <= 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ien_reg <= 1'b0;
        end
        else if (ds_wr)
        begin
            ien_reg <= reg_wdata[sbd_pkg::SBD_BIT_IRQ_ENABLE];
        end
    end

    // Tracks the phase line between bytes; frozen while a byte is mid-move
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dir_reg <= 1'b0;
        end
        else if (state_reg == sbd_pkg::SBD_ST_IDLE || step)
        begin
            dir_reg <= scsi_io;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mask_reg <= sbd_pkg::SBD_RST_IRQ_MASK;
        end
        else if (reg_wr && reg_addr == sbd_pkg::SBD_ADDR_IRQ_MASK)
        begin
            mask_reg <= reg_wdata[sbd_pkg::SBD_BIT_INT_FLAG];
        end
    end

    // ****************************************
    // Interrupt
    // ****************************************
    sbd_irq_flag u_irq (
        .clock(clock),
        .rst_n(rst_n),
        .set_evt(tip_fall && ien_reg),
        .clr_w1c(reg_wr && reg_addr == sbd_pkg::SBD_ADDR_INT_FLAG
            && reg_wdata[sbd_pkg::SBD_BIT_INT_FLAG]),
        .enable(mask_reg && ien_reg),
        .flag_reg(int_flag),
        .irq(irq)
    );

    // ****************************************
    // Read data
    // ****************************************
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata_reg <= sbd_pkg::SBD_RST_RDATA;
        end
        else if (reg_rd)
        begin
            unique case (reg_addr)
                sbd_pkg::SBD_ADDR_CTRL_STATUS:
                begin
                    rdata_reg <= {3'b000, dir_reg, tc_reg, 1'b0, ien_reg, tip_reg};
                end
                sbd_pkg::SBD_ADDR_LENGTH:
                begin
                    rdata_reg <= count;
                end
                sbd_pkg::SBD_ADDR_ADDRESS_LOW:
                begin
                    rdata_reg <= addr[7:0];
                end
                sbd_pkg::SBD_ADDR_ADDRESS_HIGH:
                begin
                    rdata_reg <= addr[15:8];
                end
                sbd_pkg::SBD_ADDR_INT_FLAG:
                begin
                    rdata_reg <= {7'b000_0000, int_flag};
                end
                sbd_pkg::SBD_ADDR_IRQ_MASK:
                begin
                    rdata_reg <= {7'b000_0000, mask_reg};
                end
                default:
                begin
                    rdata_reg <= sbd_pkg::SBD_RST_RDATA;
                end
            endcase
        end
    end

    assign reg_rdata = rdata_reg;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    sequence s_fetch;
        mem_re && mem_addr == addr;
    endsequence

    sequence s_present;
        tx_valid && tx_data == $past(mem_rdata, 1) ##0 !mem_re;
    endsequence

    a_send_path: assert property (s_fetch |=> ##1 s_present)
        else $error("fetched byte not offered to the core");

    a_count_step: assert property (step |=> count == $past(count) - 8'h01)
        else $error("count did not drop by one on a byte");

    a_addr_step: assert property (step |=> addr == $past(addr) + 16'h0001)
        else $error("address did not advance by one on a byte");

    a_last_byte: assert property (step && count != 8'h01 |=> tip_reg)
        else $error("transfer ended before the last byte");

    a_recv_dir: assert property (state_reg == sbd_pkg::SBD_ST_RECV |-> dir_reg && rx_ready)
        else $error("receive state with direction bit low");

    a_start_phase: assert property (start |=> (state_reg == sbd_pkg::SBD_ST_RECV)
        == $past(scsi_io))
        else $error("start direction not taken from the phase line");

    a_start_tip: assert property (start |=> tip_reg && !tc_reg)
        else $error("start did not raise the in-progress bit");

    a_done_flag: assert property (done |=> !tip_reg && tc_reg && count == 8'h00)
        else $error("completion not reported");

    a_tip_hold: assert property (tip_reg && !done && !abort |=> tip_reg)
        else $error("in-progress bit dropped without cause");

    a_irq_raise: assert property (tip_fall && ien_reg |=> int_flag ##0 irq == (mask_reg && ien_reg))
        else $error("no interrupt on end of transfer");

    a_irq_gate: assert property (irq |-> ien_reg && int_flag)
        else $error("interrupt active without enable");

    a_idle_hold: assert property (!tip_reg && !reg_wr |=> $stable(addr) && $stable(count))
        else $error("address or count moved while stopped");

    a_status_read: assert property (reg_rd && reg_addr == sbd_pkg::SBD_ADDR_LENGTH
        |=> reg_rdata == $past(count))
        else $error("length read does not show the remaining count");

endmodule

//--- verilog/sbd_pkg.sv
// Constants shared by the byte DMA mover: register offsets, bit positions,
// reset values and the engine state encoding.
// Assumes an 8-bit register port addressed by the 16-bit printed offsets.
package sbd_pkg;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [15:0] SBD_ADDR_CTRL_STATUS = 16'hfc10;
    localparam logic [15:0] SBD_ADDR_LENGTH = 16'hfc11;
    localparam logic [15:0] SBD_ADDR_ADDRESS_LOW = 16'hfc12;
    localparam logic [15:0] SBD_ADDR_ADDRESS_HIGH = 16'hfc13;
    localparam logic [15:0] SBD_ADDR_INT_FLAG = 16'hfc14;
    localparam logic [15:0] SBD_ADDR_IRQ_MASK = 16'hfc15;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int SBD_BIT_IN_PROGRESS = 0;
    localparam int SBD_BIT_IRQ_ENABLE = 1;
    localparam int SBD_BIT_COMPLETION = 3;
    localparam int SBD_BIT_DIRECTION = 4;
    localparam int SBD_BIT_INT_FLAG = 0;

    // ****************************************
    // Reset values and step constants
    // ****************************************
    localparam logic [7:0] SBD_RST_LENGTH = 8'h00;
    localparam logic [7:0] SBD_RST_ADDRESS_BYTE = 8'h00;
    localparam logic SBD_RST_IRQ_MASK = 1'b1;
    localparam logic [7:0] SBD_RST_RDATA = 8'h00;
    localparam logic [7:0] SBD_COUNT_ONE = 8'h01;
    localparam logic [15:0] SBD_ADDR_ONE = 16'h0001;

    // ****************************************
    // Engine states
    // ****************************************
    typedef enum logic [2:0] {
        SBD_ST_IDLE = 3'b000,
        SBD_ST_FETCH = 3'b001,
        SBD_ST_LATCH = 3'b010,
        SBD_ST_SEND = 3'b011,
        SBD_ST_RECV = 3'b100,
        SBD_ST_WRITE = 3'b101
    } sbd_state_e;

endpackage

//--- verilog/sbd_irq_flag.sv
// Sticky interrupt flag: set by a hardware event, cleared by writing a one.
// Assumes set and clear are one-cycle pulses in the clock domain.
`timescale 1ns/100ps
module sbd_irq_flag (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Event and software clear
    input wire logic set_evt,
    input wire logic clr_w1c,
    input wire logic enable,
    // Status and request
    output logic flag_reg,
    output logic irq
);

    // Set beats clear so an event in the clearing cycle is kept
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            flag_reg <= 1'b0;
        end
        else if (set_evt)
        begin
            flag_reg <= 1'b1;
        end
        else if (clr_w1c)
        begin
            flag_reg <= 1'b0;
        end
    end

    assign irq = flag_reg & enable;

endmodule

//--- verilog/sbd_xfer_ctr.sv
// Address and remaining-count registers of the mover.
// Assumes loads only arrive while no transfer runs; a step wins otherwise.
`timescale 1ns/100ps
module sbd_xfer_ctr (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Software loads
    input wire logic load_len,
    input wire logic load_lo,
    input wire logic load_hi,
    input wire logic [7:0] load_data,
    // Engine advance
    input wire logic step,
    // Current values
    output logic [7:0] count_reg,
    output logic [15:0] addr_reg
);

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count_reg <= sbd_pkg::SBD_RST_LENGTH;
        end
        else if (step)
        begin
            count_reg <= count_reg - sbd_pkg::SBD_COUNT_ONE;
        end
        else if (load_len)
        begin
            count_reg <= load_data;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            addr_reg <= {sbd_pkg::SBD_RST_ADDRESS_BYTE, sbd_pkg::SBD_RST_ADDRESS_BYTE};
        end
        else if (step)
        begin
            addr_reg <= addr_reg + sbd_pkg::SBD_ADDR_ONE;
        end
        else if (load_lo)
        begin
            addr_reg[7:0] <= load_data;
        end
        else if (load_hi)
        begin
            addr_reg[15:8] <= load_data;
        end
    end

endmodule

//--- dv/sbd_far_model.sv
// Far-side model of the byte mover: SCSI core byte ports and on-chip memory.
// Assumes the mover's valid/ready byte ports and a one-cycle memory read.
`timescale 1ns/100ps
module sbd_far_model (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Pacing: idle cycles before each answer, and leave to offer bytes
    input wire logic [7:0] slow,
    input wire logic rx_en,
    // Core side
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    output logic [7:0] rx_data,
    output logic rx_valid,
    input wire logic rx_ready,
    // Memory side
    input wire logic [15:0] mem_addr,
    input wire logic mem_re,
    output logic [7:0] mem_rdata,
    input wire logic mem_we,
    input wire logic [7:0] mem_wdata
);
    logic [7:0] mem [0:65535];
    logic [7:0] tx_log [0:255];
    logic [7:0] tx_wait, rx_wait, tx_n;
    logic [15:0] rx_n;

    initial
    begin
        mem_rdata = 8'h00;
        for (int i = 0; i < 65536; i++)
            mem[i] = i[7:0] ^ i[15:8] ^ 8'h5a;
    end

    // Read data is only good in the cycle after the strobe; toggle otherwise
    always @(posedge clock)
    begin
        if (mem_we)
            mem[mem_addr] <= mem_wdata;
        mem_rdata <= mem_re ? mem[mem_addr] : ~mem_rdata;
    end

    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_ready <= 1'b0;
            tx_wait <= 8'h00;
            tx_n <= 8'h00;
            rx_valid <= 1'b0;
            rx_data <= 8'h00;
            rx_wait <= 8'h00;
            rx_n <= 16'h0000;
        end
        else
        begin
            tx_ready <= 1'b0;
            if (tx_valid && tx_ready)
            begin
                tx_log[tx_n] <= tx_data;
                tx_n <= tx_n + 8'h01;
                tx_wait <= 8'h00;
            end
            // Core transfer engine is taken as enabled by software before any send
            else if (tx_valid && tx_wait >= slow)
                tx_ready <= 1'b1;
            else if (tx_valid)
                tx_wait <= tx_wait + 8'h01;
            // A released byte is inverted so a late sample cannot match
            if (rx_valid && rx_ready)
            begin
                rx_valid <= 1'b0;
                rx_data <= ~rx_data;
                rx_n <= rx_n + 16'h0001;
                rx_wait <= 8'h00;
            end
            else if (rx_en && !rx_valid && rx_wait >= slow)
            begin
                rx_valid <= 1'b1;
                rx_data <= 8'ha0 + rx_n[7:0];
            end
            else if (rx_en && !rx_valid)
                rx_wait <= rx_wait + 8'h01;
        end
    end
endmodule

//--- dv/tb.sv
// Self-checking bench for the byte mover: register tasks drive transfers
// both ways against the far-side model. Assumes one 40 MHz clock.
`timescale 1ns/100ps
module tb;
    localparam logic [15:0] CS = sbd_pkg::SBD_ADDR_CTRL_STATUS;
    localparam logic [15:0] LEN = sbd_pkg::SBD_ADDR_LENGTH;
    localparam logic [15:0] ALO = sbd_pkg::SBD_ADDR_ADDRESS_LOW;
    localparam logic [15:0] AHI = sbd_pkg::SBD_ADDR_ADDRESS_HIGH;
    localparam logic [15:0] IFL = sbd_pkg::SBD_ADDR_INT_FLAG;
    localparam logic [15:0] MSK = sbd_pkg::SBD_ADDR_IRQ_MASK;
    logic clock, rst_n, reg_wr, reg_rd, scsi_io, irq;
    logic [15:0] reg_addr, mem_addr;
    logic [7:0] reg_wdata, reg_rdata, tx_data, rx_data, mem_rdata, mem_wdata, slow, d;
    logic tx_valid, tx_ready, rx_valid, rx_ready, mem_re, mem_we;
    int n_mismatch = 0;
    int num_checks = 0;
    int cycles = 0;

    sbd_mover uut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .scsi_io(scsi_io), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .mem_addr(mem_addr),
        .mem_re(mem_re), .mem_rdata(mem_rdata), .mem_we(mem_we), .mem_wdata(mem_wdata),
        .irq(irq));
    sbd_far_model far (.clock(clock), .rst_n(rst_n), .slow(slow), .rx_en(scsi_io),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .mem_addr(mem_addr), .mem_re(mem_re),
        .mem_rdata(mem_rdata), .mem_we(mem_we), .mem_wdata(mem_wdata));

    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Cuts a hang short; the longest run needs well under a tenth of this
    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            n_mismatch++;
            stop_test();
        end
    end

    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, output logic [7:0] v);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(negedge clock);
        v = reg_rdata;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic exp);
        @(negedge clock);
        num_checks++;
        if (irq !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: irq %b expected %b", $time, irq, exp);
        end
    endtask

    task automatic rdchk(input logic [15:0] a, input logic [7:0] exp);
        rd(a, d);
        chk8(d, exp);
    endtask

    // Polls the busy bit; the timeout catches a transfer that never ends
    task automatic wait_idle();
        d = 8'h01;
        while (d[0] !== 1'b0)
            rd(CS, d);
    endtask

    function automatic logic [7:0] pat(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5a;
    endfunction

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        rst_n = 1'b0;
        reg_addr = 16'h0000;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        scsi_io = 1'b0;
        slow = 8'h02;
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        rdchk(CS, 8'h00);
        rdchk(LEN, 8'h00);
        rdchk(ALO, 8'h00);
        rdchk(AHI, 8'h00);
        rdchk(IFL, 8'h00);
        rdchk(MSK, 8'h01);
        rdchk(16'hfc16, 8'h00);
        // Send across a low-byte carry; software direction bit must not matter
        wr(LEN, 8'h03);
        wr(ALO, 8'hfe);
        wr(AHI, 8'h12);
        wr(CS, 8'h13);
        wait_idle();
        for (int k = 0; k < 3; k++)
            chk8(far.tx_log[k], pat(16'(16'h12fe + k)));
        chk8(far.tx_n, 8'h03);
        rdchk(CS, 8'h0a);
        rdchk(LEN, 8'h00);
        rdchk(ALO, 8'h01);
        rdchk(AHI, 8'h13);
        rdchk(IFL, 8'h01);
        chk1(1'b1);
        wr(MSK, 8'h00);
        chk1(1'b0);
        wr(MSK, 8'h01);
        chk1(1'b1);
        wr(CS, 8'h00);
        chk1(1'b0);
        wr(CS, 8'h02);
        chk1(1'b1);
        wr(IFL, 8'h01);
        chk1(1'b0);
        rdchk(IFL, 8'h00);
        // Receive of 256 bytes from a zero length, no interrupt enabled
        @(posedge clock);
        scsi_io <= 1'b1;
        slow <= 8'h00;
        wr(LEN, 8'h00);
        wr(ALO, 8'h00);
        wr(AHI, 8'h30);
        wr(CS, 8'h01);
        wait_idle();
        for (int k = 0; k < 256; k++)
            chk8(far.mem[16'h3000 + k], 8'(8'ha0 + k[7:0]));
        rdchk(CS, 8'h18);
        rdchk(LEN, 8'h00);
        rdchk(AHI, 8'h31);
        rdchk(IFL, 8'h00);
        chk1(1'b0);
        // Slow receive stopped after two bytes, then resumed
        @(posedge clock);
        slow <= 8'h14;
        wr(LEN, 8'h05);
        wr(ALO, 8'h00);
        wr(AHI, 8'h40);
        wr(CS, 8'h03);
        wr(LEN, 8'h77);
        while (far.rx_n != 16'h0102)
            @(posedge clock);
        repeat (4) @(posedge clock);
        wr(CS, 8'h02);
        rdchk(CS, 8'h12);
        rdchk(LEN, 8'h03);
        rdchk(ALO, 8'h02);
        rdchk(AHI, 8'h40);
        rdchk(IFL, 8'h01);
        chk1(1'b1);
        wr(IFL, 8'h01);
        wr(CS, 8'h01);
        wait_idle();
        for (int k = 0; k < 5; k++)
            chk8(far.mem[16'h4000 + k], 8'(8'ha0 + k[7:0]));
        rdchk(CS, 8'h18);
        rdchk(ALO, 8'h05);
        rdchk(LEN, 8'h00);
        stop_test();
    end
endmodule
